//--- rtl/rtcirq_irq_ctrl.sv
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Writing one clears overflow enable
// - Clear and set views share enables
// - Writing one clears tamper enable
// - Two compare enables in 32-bit mode
// - Eight periodic enables, zero writes ignored
// - Overflow flag set on the counter tick after overflow
// - Writing one clears a flag
// - Tamper flag set on detection
// - Four compare flags in 16-bit mode
// - Periodic flag n on prescaler bit n+2 rise
module rtcirq_irq_ctrl
  import rtcirq_pkg::*;
#(
  parameter int PRESC_W = 10 // Prescaler width, needs n+2 taps
) (
  input wire logic i_ref_clk, // System clock
  input wire logic i_sys_rst, // Synchronous reset, high
  input wire logic i_cnt_tick, // Counter clock enable pulse
  input wire logic i_overflow, // Overflow seen this tick
  input wire logic i_tamper, // Tamper detected pulse
  input wire logic [rtcirq_pkg::RTCIRQ_NUM_CMP16-1:0] i_cmp_match, // Matches
  input wire logic [PRESC_W-1:0] i_prescaler, // Prescaler value
  output logic [1:0] o_mode, // Operating mode field
  output logic o_irq, // Level interrupt
  input wire logic [7:0] i_s_axi_awaddr, // Write address
  input wire logic i_s_axi_awvalid, // Write address valid
  output logic o_s_axi_awready, // Write address ready
  input wire logic [31:0] i_s_axi_wdata, // Write data
  input wire logic [3:0] i_s_axi_wstrb, // Write strobes
  input wire logic i_s_axi_wvalid, // Write data valid
  output logic o_s_axi_wready, // Write data ready
  output logic [1:0] o_s_axi_bresp, // Write response
  output logic o_s_axi_bvalid, // Write response valid
  input wire logic i_s_axi_bready, // Write response ready
  input wire logic [7:0] i_s_axi_araddr, // Read address
  input wire logic i_s_axi_arvalid, // Read address valid
  output logic o_s_axi_arready, // Read address ready
  output logic [31:0] o_s_axi_rdata, // Read data
  output logic [1:0] o_s_axi_rresp, // Read response
  output logic o_s_axi_rvalid, // Read valid
  input wire logic i_s_axi_rready // Read ready
);
  import rtcirq_pkg::*;

  localparam int NPERT = RTCIRQ_NUM_PER + RTCIRQ_PER_OFS;

  // Periodic taps need prescaler bits up to 9
  initial begin
    if (PRESC_W < NPERT) begin
      $error("PRESC_W too small for periodic taps");
    end
  end

  // Write channel capture, address and data in either order
  logic [7:0] awaddr_q;
  logic aw_have_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic w_have_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic aw_hs;
  logic w_hs;
  logic wr_fire;

  assign o_s_axi_awready = ~aw_have_q & ~bvalid_q;
  assign o_s_axi_wready = ~w_have_q & ~bvalid_q;
  assign aw_hs = i_s_axi_awvalid & o_s_axi_awready;
  assign w_hs = i_s_axi_wvalid & o_s_axi_wready;
  assign wr_fire = aw_have_q & w_have_q & ~bvalid_q;

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      aw_have_q <= 1'b0;
      awaddr_q <= 8'h00;
    end else if (aw_hs) begin
      aw_have_q <= 1'b1;
      awaddr_q <= i_s_axi_awaddr;
    end else if (wr_fire) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      w_have_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (w_hs) begin
      w_have_q <= 1'b1;
      wdata_q <= i_s_axi_wdata;
      wstrb_q <= i_s_axi_wstrb;
    end else if (wr_fire) begin
      w_have_q <= 1'b0;
    end
  end

  // Word decode; the enable set view lives in the upper half of 0x08
  logic [7:0] wr_word;
  logic wr_en_word;
  logic wr_flag;
  logic wr_mode;
  logic wr_hit;
  logic [15:0] wlo;
  logic [15:0] whi;

  assign wr_word = {awaddr_q[7:2], 2'b00};
  assign wr_en_word = wr_fire & (wr_word == RTCIRQ_OFS_ENCLR);
  assign wr_flag = wr_fire & (wr_word == RTCIRQ_OFS_FLAG);
  assign wr_mode = wr_fire & (wr_word == RTCIRQ_OFS_MODE);
  assign wr_hit = wr_en_word | wr_flag | wr_mode;
  // Byte strobes mask the written ones
  assign wlo = wdata_q[15:0] & {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  assign whi = wdata_q[31:16] & {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}};

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      bvalid_q <= 1'b0;
      bresp_q <= RTCIRQ_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_hit ? RTCIRQ_RESP_OKAY : RTCIRQ_RESP_SLVERR;
    end else if (i_s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  assign o_s_axi_bvalid = bvalid_q;
  assign o_s_axi_bresp = bresp_q;

  // Mode field, steers which compare bits are live
  logic [1:0] mode_q;
  logic mode16;

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      mode_q <= RTCIRQ_RST_MODE;
    end else if (wr_mode & wstrb_q[0]) begin
      mode_q <= wdata_q[1:0];
    end
  end

  assign o_mode = mode_q;
  assign mode16 = (mode_q == RTCIRQ_MODE_SIXTEEN_BIT_COUNTING);

  // Implemented enable bits depend on the counting mode
  logic [15:0] cmp_mask;
  logic [15:0] live_mask;

  assign cmp_mask = mode16 ? 16'h0F00 : 16'h0300;
  assign live_mask = cmp_mask | 16'hC0FF;

  // One shared enable state for the clear and set views
  logic [15:0] en_q;
  logic [15:0] en_d;
  logic [15:0] en_clr;
  logic [15:0] en_set;

  // Zero bits leave an enable alone
  assign en_clr = wr_en_word ? (wlo & live_mask) : 16'h0000;
  assign en_set = wr_en_word ? (whi & live_mask) : 16'h0000;
  assign en_d = (en_q & ~en_clr) | en_set;

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      en_q <= RTCIRQ_RST_EN;
    end else begin
      en_q <= en_d;
    end
  end

  // Counter-clock-timed events, registered so flags rise a tick later
  logic ovf_ev_q;
  logic [RTCIRQ_NUM_CMP16-1:0] cmp_ev_q;
  logic [RTCIRQ_NUM_CMP16-1:0] cmp_live;

  assign cmp_live = mode16 ? 4'hF : 4'h3;

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      ovf_ev_q <= 1'b0;
      cmp_ev_q <= '0;
    end else if (i_cnt_tick) begin
      ovf_ev_q <= i_overflow;
      cmp_ev_q <= i_cmp_match & cmp_live;
    end
  end

  // Event becomes a flag only on the following counter tick
  logic ovf_set;
  logic [RTCIRQ_NUM_CMP16-1:0] cmp_set;

  assign ovf_set = i_cnt_tick & ovf_ev_q;
  assign cmp_set = {RTCIRQ_NUM_CMP16{i_cnt_tick}} & cmp_ev_q;

  // Periodic ticks from prescaler taps 2..9
  logic [RTCIRQ_NUM_PER-1:0] per_set;

  rtcirq_rise_det #(
    .WIDTH(RTCIRQ_NUM_PER)
  ) u_per_rise (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_en(1'b1),
    .i_level(i_prescaler[NPERT-1:RTCIRQ_PER_OFS]),
    .o_rise(per_set)
  );

  // Flag vector set and clear lanes
  logic [15:0] flag_set;
  logic [15:0] flag_clr;
  logic [15:0] flag_q;

  assign flag_set = {ovf_set, i_tamper, 2'b00, cmp_set, per_set};
  assign flag_clr = wr_flag ? (wlo & live_mask) : 16'h0000;

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_flag
      if (RTCIRQ_RST_FLAG[gi] == 1'b0 && (gi < 12 || gi > 13)) begin : g_on
        rtcirq_flag_bit u_flag (
          .i_ref_clk(i_ref_clk),
          .i_sys_rst(i_sys_rst),
          .i_set(flag_set[gi]),
          .i_clr(flag_clr[gi]),
          .o_flag(flag_q[gi])
        );
      end else begin : g_off
        assign flag_q[gi] = 1'b0;
      end
    end
  endgenerate

  // Request while any enabled flag stands
  assign o_irq = |(flag_q & en_q & live_mask);

  // Read channel, one outstanding read, data registered
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [7:0] rd_word;
  logic rd_hit;
  logic [31:0] rd_mux;

  assign o_s_axi_arready = ~rvalid_q;
  assign rd_word = {i_s_axi_araddr[7:2], 2'b00};
  assign rd_hit = (rd_word == RTCIRQ_OFS_ENCLR) |
                  (rd_word == RTCIRQ_OFS_FLAG) |
                  (rd_word == RTCIRQ_OFS_MODE);
  // Both enable views read the same state
  assign rd_mux =
    (rd_word == RTCIRQ_OFS_ENCLR) ? {en_q & live_mask, en_q & live_mask} :
    (rd_word == RTCIRQ_OFS_FLAG) ? {16'h0000, flag_q & live_mask} :
    (rd_word == RTCIRQ_OFS_MODE) ? {30'h0000_0000, mode_q} :
    32'h0000_0000;

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RTCIRQ_RESP_OKAY;
    end else if (i_s_axi_arvalid & ~rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= rd_hit ? RTCIRQ_RESP_OKAY : RTCIRQ_RESP_SLVERR;
    end else if (i_s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign o_s_axi_rvalid = rvalid_q;
  assign o_s_axi_rdata = rdata_q;
  assign o_s_axi_rresp = rresp_q;
endmodule : rtcirq_irq_ctrl
`default_nettype wire

//--- shared/rtcirq_pkg.sv
`default_nettype none
package rtcirq_pkg;
  // Register byte addresses on the AXI4-Lite slave
  localparam logic [7:0] RTCIRQ_OFS_ENCLR = 8'h08;
  localparam logic [7:0] RTCIRQ_OFS_ENSET = 8'h0A;
  localparam logic [7:0] RTCIRQ_OFS_FLAG = 8'h0C;
  localparam logic [7:0] RTCIRQ_OFS_MODE = 8'h10;
  // Field positions inside the enable and flag words
  localparam int RTCIRQ_BIT_OVF = 15;
  localparam int RTCIRQ_BIT_TAMPER = 14;
  localparam int RTCIRQ_BIT_CMP_LO = 8;
  localparam int RTCIRQ_NUM_CMP32 = 2;
  localparam int RTCIRQ_NUM_CMP16 = 4;
  localparam int RTCIRQ_NUM_PER = 8;
  localparam int RTCIRQ_PER_OFS = 2;
  // Reset values
  localparam logic [15:0] RTCIRQ_RST_EN = 16'h0000;
  localparam logic [15:0] RTCIRQ_RST_FLAG = 16'h0000;
  // Operating mode field encodings
  typedef enum logic [1:0] {
    RTCIRQ_MODE_THIRTY_TWO_BIT_COUNTING = 2'h0,
    RTCIRQ_MODE_SIXTEEN_BIT_COUNTING = 2'h1
  } rtcirq_mode_t;
  localparam logic [1:0] RTCIRQ_RST_MODE = 2'h0;
  // AXI response codes
  localparam logic [1:0] RTCIRQ_RESP_OKAY = 2'h0;
  localparam logic [1:0] RTCIRQ_RESP_SLVERR = 2'h2;
endpackage : rtcirq_pkg
`default_nettype wire

//--- rtl/rtcirq_rise_det.sv
`timescale 1ns/1ps
`default_nettype none
// Rising edge detector for a same-domain level, one-cycle pulse out
module rtcirq_rise_det #(
  parameter int WIDTH = 8 // Number of lanes
) (
  input wire logic i_ref_clk, // System clock
  input wire logic i_sys_rst, // Synchronous reset, high
  input wire logic i_en, // Sample enable
  input wire logic [WIDTH-1:0] i_level, // Levels to watch
  output logic [WIDTH-1:0] o_rise // One-cycle rise pulses
);
  logic [WIDTH-1:0] prev_q;

  // Old value held while disabled so no edge is missed across gaps
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      prev_q <= '0;
    end else if (i_en) begin
      prev_q <= i_level;
    end
  end

  assign o_rise = i_en ? (i_level & ~prev_q) : '0;
endmodule : rtcirq_rise_det
`default_nettype wire

//--- rtl/rtcirq_flag_bit.sv
`timescale 1ns/1ps
`default_nettype none
// One sticky flag: set on event, clear on write-one, set wins
module rtcirq_flag_bit (
  input wire logic i_ref_clk, // System clock
  input wire logic i_sys_rst, // Synchronous reset, high
  input wire logic i_set, // Hardware event pulse
  input wire logic i_clr, // Software write-one pulse
  output logic o_flag // Sticky flag
);
  logic flag_q;
  logic flag_d;

  // Event beats a clear in the same cycle
  assign flag_d = i_set | (flag_q & ~i_clr);

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign o_flag = flag_q;
endmodule : rtcirq_flag_bit
`default_nettype wire

//--- testbench/rtcirq_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// Bus handshake and interrupt relations at the ports
module rtcirq_monitor
  import rtcirq_pkg::*;
#(
  parameter int PRESC_W = 10 // Prescaler width
) (
  input wire logic i_ref_clk, // Clock
  input wire logic i_sys_rst, // Reset
  input wire logic i_cnt_tick, // Tick
  input wire logic i_tamper, // Tamper
  input wire logic [PRESC_W-1:0] i_prescaler, // Prescaler
  input wire logic o_irq, // Interrupt
  input wire logic i_s_axi_awvalid, // Aw valid
  input wire logic o_s_axi_awready, // Aw ready
  input wire logic i_s_axi_wvalid, // W valid
  input wire logic o_s_axi_wready, // W ready
  input wire logic o_s_axi_bvalid, // B valid
  input wire logic i_s_axi_bready, // B ready
  input wire logic i_s_axi_arvalid, // Ar valid
  input wire logic o_s_axi_arready, // Ar ready
  input wire logic [31:0] o_s_axi_rdata, // R data
  input wire logic [1:0] o_s_axi_rresp, // R resp
  input wire logic o_s_axi_rvalid, // R valid
  input wire logic i_s_axi_rready // R ready
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_sys_rst);
  // Write answer two edges after a joint address and data
  chk_wr_answer: assert property (i_s_axi_awvalid && o_s_axi_awready &&
    i_s_axi_wvalid && o_s_axi_wready |-> ##2 o_s_axi_bvalid)
    else $error("write answer late");
  chk_aw_refuse: assert property (o_s_axi_bvalid |->
    !o_s_axi_awready && !o_s_axi_wready) else $error("write not refused");
  chk_b_single: assert property (o_s_axi_bvalid && i_s_axi_bready |=>
    !o_s_axi_bvalid && o_s_axi_awready) else $error("write answer stuck");
  chk_rd_answer: assert property (i_s_axi_arvalid && o_s_axi_arready |=>
    o_s_axi_rvalid && !o_s_axi_arready) else $error("read answer late");
  chk_r_single: assert property (o_s_axi_rvalid && i_s_axi_rready |=>
    !o_s_axi_rvalid) else $error("read answer stuck");
  chk_err_zero: assert property (o_s_axi_rvalid &&
    o_s_axi_rresp == RTCIRQ_RESP_SLVERR |-> o_s_axi_rdata == 32'h0)
    else $error("error read carries data");
  // A request only appears after an event or a register write
  chk_irq_cause: assert property ($rose(o_irq) |->
    $past(i_tamper) || $past(i_cnt_tick) || $rose(o_s_axi_bvalid) ||
    $past(i_prescaler) != $past(i_prescaler, 2)) else $error("irq uncaused");
  chk_irq_drop: assert property ($fell(o_irq) |->
    $rose(o_s_axi_bvalid)) else $error("irq dropped without write");
  cov_irq: cover property ($rose(o_irq));
  cov_err: cover property (o_s_axi_rvalid && o_s_axi_rresp != 2'h0);
  cov_wr: cover property ($rose(o_s_axi_bvalid));
endmodule : rtcirq_monitor
bind rtcirq_irq_ctrl rtcirq_monitor #(.PRESC_W(PRESC_W)) u_mon (.i_ref_clk,
  .i_sys_rst, .i_cnt_tick, .i_tamper, .i_prescaler, .o_irq, .i_s_axi_awvalid,
  .o_s_axi_awready, .i_s_axi_wvalid, .o_s_axi_wready, .o_s_axi_bvalid,
  .i_s_axi_bready, .i_s_axi_arvalid, .o_s_axi_arready, .o_s_axi_rdata,
  .o_s_axi_rresp, .o_s_axi_rvalid, .i_s_axi_rready);
`default_nettype wire

//--- testbench/counter_interrupt_flags_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, x) begin checks_done++; if ((a) !== (x)) begin err_count++; \
  $display("BAD %0t got %h want %h", $time, a, x); end end
module counter_interrupt_flags_tb;
  import rtcirq_pkg::*;
  logic i_ref_clk = 0, i_sys_rst = 1, i_cnt_tick = 0, i_overflow = 0;
  logic i_tamper = 0, pre_run = 0;
  logic [3:0] i_cmp_match = 4'h0, i_s_axi_wstrb = 4'hF;
  logic [9:0] i_prescaler = 10'h000;
  logic [7:0] i_s_axi_awaddr = 8'h00, i_s_axi_araddr = 8'h00;
  logic [31:0] i_s_axi_wdata = 32'h0, o_s_axi_rdata;
  logic i_s_axi_awvalid = 0, i_s_axi_wvalid = 0, i_s_axi_bready = 0;
  logic i_s_axi_arvalid = 0, i_s_axi_rready = 0;
  logic [1:0] o_mode, o_s_axi_bresp, o_s_axi_rresp;
  logic o_irq, o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid;
  logic o_s_axi_arready, o_s_axi_rvalid;
  logic [17:0] exp_q[$];
  logic [15:0] r;
  logic [1:0] ok = RTCIRQ_RESP_OKAY;
  int err_count = 0, checks_done = 0, cyc = 0;
  rtcirq_irq_ctrl #(.PRESC_W(10)) dut (.*);
  initial forever #2 i_ref_clk = ~i_ref_clk;
  // Free-running prescaler only while enabled, so edges are countable
  always @(posedge i_ref_clk) begin
    if (pre_run) i_prescaler <= i_prescaler + 10'h001;
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      err_count++;
      complete_run();
    end
  end
  // Read answers matched against the oldest expectation
  always @(posedge i_ref_clk) begin
    if (o_s_axi_rvalid && i_s_axi_rready) begin
      `CHK({o_s_axi_rresp, o_s_axi_rdata[15:0]}, exp_q.pop_front())
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] x);
    i_s_axi_awaddr <= a;
    i_s_axi_wdata <= d;
    i_s_axi_awvalid <= 1;
    i_s_axi_wvalid <= 1;
    i_s_axi_bready <= 1;
    do begin
      @(posedge i_ref_clk);
      if (o_s_axi_awready) i_s_axi_awvalid <= 0;
      if (o_s_axi_wready) i_s_axi_wvalid <= 0;
    end while (!o_s_axi_bvalid);
    i_s_axi_bready <= 0;
    `CHK(o_s_axi_bresp, x)
    @(posedge i_ref_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [17:0] x);
    exp_q.push_back(x);
    i_s_axi_araddr <= a;
    i_s_axi_arvalid <= 1;
    i_s_axi_rready <= 1;
    do begin
      @(posedge i_ref_clk);
      if (o_s_axi_arready) i_s_axi_arvalid <= 0;
    end while (!o_s_axi_rvalid);
    i_s_axi_rready <= 0;
    @(posedge i_ref_clk);
  endtask : rd
  // One tick with events, then idle ticks so the flag lands
  task automatic ev(input logic ov, input logic tp, input logic [3:0] cm);
    i_cnt_tick <= 1;
    i_overflow <= ov;
    i_tamper <= tp;
    i_cmp_match <= cm;
    @(posedge i_ref_clk);
    i_overflow <= 0;
    i_tamper <= 0;
    i_cmp_match <= 4'h0;
    repeat (3) @(posedge i_ref_clk);
    i_cnt_tick <= 0;
    @(posedge i_ref_clk);
  endtask : ev
  task automatic complete_run();
    if (err_count == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run
  initial begin
    r = 16'($urandom(27916));
    repeat (8) @(posedge i_ref_clk);
    i_sys_rst <= 0;
    @(posedge i_ref_clk);
    rd(8'h08, {ok, 16'h0000});
    rd(8'h0C, {ok, 16'h0000});
    rd(8'h20, {RTCIRQ_RESP_SLVERR, 16'h0000});
    wr(8'h20, 32'hFFFFFFFF, RTCIRQ_RESP_SLVERR);
    wr(8'h08, 32'hFFFF0000, ok);
    rd(8'h08, {ok, 16'hC3FF});
    wr(8'h08, 32'h0, ok);
    rd(8'h08, {ok, 16'hC3FF});
    wr(8'h08, 32'h8000, ok);
    rd(8'h08, {ok, 16'h43FF});
    wr(8'h08, 32'h4000, ok);
    rd(8'h08, {ok, 16'h03FF});
    r = 16'($urandom()) & 16'h03FF;
    wr(8'h08, {16'h0, r}, ok);
    rd(8'h08, {ok, 16'h03FF & ~r});
    wr(8'h08, 32'hFFFF0000, ok);
    pre_run <= 1;
    repeat (1100) @(posedge i_ref_clk);
    pre_run <= 0;
    rd(8'h0C, {ok, 16'h00FF});
    `CHK(o_irq, 1'b1)
    wr(8'h0C, 32'h0, ok);
    rd(8'h0C, {ok, 16'h00FF});
    wr(8'h0C, 32'h00FF, ok);
    rd(8'h0C, {ok, 16'h0000});
    `CHK(o_irq, 1'b0)
    ev(1, 0, 4'h0);
    rd(8'h0C, {ok, 16'h8000});
    `CHK(o_irq, 1'b1)
    wr(8'h08, 32'h8000, ok);
    `CHK(o_irq, 1'b0)
    wr(8'h0C, 32'h8000, ok);
    ev(0, 1, 4'h0);
    rd(8'h0C, {ok, 16'h4000});
    `CHK(o_irq, 1'b1)
    wr(8'h08, 32'h4000, ok);
    `CHK(o_irq, 1'b0)
    // Tamper held across its own clear: the event must survive
    i_tamper <= 1;
    wr(8'h0C, 32'h4000, ok);
    i_tamper <= 0;
    rd(8'h0C, {ok, 16'h4000});
    wr(8'h0C, 32'h4000, ok);
    for (int m = 0; m < 2; m++) begin
      wr(8'h10, m, ok);
      ev(0, 0, 4'hF);
      rd(8'h0C, {ok, m ? 16'h0F00 : 16'h0300});
      `CHK(o_irq, 1'b1)
      wr(8'h0C, 32'hFFFF, ok);
    end
    complete_run();
  end
endmodule : counter_interrupt_flags_tb
`default_nettype wire
